/* hw/peci_fan_start_temperature_pkg.sv */
package peci_fan_start_temperature_pkg;
  // register map
  localparam logic [7:0] CTRL_OFFSET = 8'h90;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int ENABLE_BIT = 7;
  localparam int OPCAP_BIT = 6;
  localparam int CYC_MSB = 5;
  localparam int CYC_LSB = 3;
  localparam logic [7:0] CTRL_WMASK = 8'hF8;
  // timing
  localparam int CORE_CLK_HZ = 10_000_000;
  localparam int MON_CYCLES_PER_SEC = 8;
  localparam int MON_PERIOD_CLKS = CORE_CLK_HZ / MON_CYCLES_PER_SEC;
  localparam int DEC_BASE_CYCLES = 8;
  localparam int INC_BASE_CYCLES = 16;
  localparam int WAIT_W = 12;

  typedef struct packed {
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic up_req;
    logic down_req;
  } adj_req_t;
endpackage

/* hw/mon_cycle_tick.sv */
`timescale 1ns/10ps
// one-cycle enable pulse every PERIOD clocks
module mon_cycle_tick #(
  parameter int PERIOD = 1250000
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  output logic tick_out
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;

  always_comb begin
    if (cnt_r >= 32'(PERIOD - 1)) begin
      cnt_nxt = 32'h0;
    end else begin
      cnt_nxt = cnt_r + 32'h1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      cnt_r <= 32'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tick_out = (cnt_r == 32'(PERIOD - 1));
endmodule // mon_cycle_tick

/* hw/peci_fan_start_temperature_cycle_timing.sv */
`timescale 1ns/10ps
module peci_fan_start_temperature_cycle_timing
  import peci_fan_start_temperature_pkg::*;
#(
  parameter int MON_PERIOD = MON_PERIOD_CLKS
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // register port
  input wire reg_req_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  input wire logic lock_in,
  // control loop
  input wire adj_req_t adj_req_in,
  output logic adj_up_out,
  output logic adj_down_out,
  output logic [2:0] peci_cycle_select_out,
  output logic dyn_enable_out
);
  ////////////////////////////////////////////////////////////////////////
  // control register
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic hit;

  assign hit = (reg_req_in.addr == CTRL_OFFSET);

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (reg_req_in.write && hit && !lock_in) begin
      ctrl_nxt = reg_req_in.wdata & CTRL_WMASK;
    end
    rdata_nxt = hit ? (ctrl_r & CTRL_WMASK) : 8'h00;
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      ctrl_r <= CTRL_RESET;
      rdata_r <= 8'h00;
    end else begin
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign peci_cycle_select_out = ctrl_r[CYC_MSB:CYC_LSB];
  assign dyn_enable_out = ctrl_r[ENABLE_BIT];

  ////////////////////////////////////////////////////////////////////////
  // monitoring cycle pacing, eight per second
  logic mon_tick;

  mon_cycle_tick #(
    .PERIOD(MON_PERIOD)
  ) u_tick (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .tick_out(mon_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // adjustment spacing
  logic [WAIT_W-1:0] dec_wait;
  logic [WAIT_W-1:0] inc_wait;
  logic [WAIT_W-1:0] elapsed_r;
  logic [WAIT_W-1:0] elapsed_nxt;
  logic up_r;
  logic up_nxt;
  logic down_r;
  logic down_nxt;

  // increase always waits twice the decrease wait
  assign dec_wait = WAIT_W'(DEC_BASE_CYCLES) << peci_cycle_select_out;
  assign inc_wait = WAIT_W'(INC_BASE_CYCLES) << peci_cycle_select_out;

  always_comb begin
    elapsed_nxt = elapsed_r;
    up_nxt = 1'b0;
    down_nxt = 1'b0;
    if (!dyn_enable_out) begin
      elapsed_nxt = '0;
    end else if (mon_tick) begin
      // saturate so a long idle spell does not wrap and block a step
      if (elapsed_r != '1) begin
        elapsed_nxt = elapsed_r + 1'b1;
      end
      // decrease has priority: it is the cooler, quieter direction
      // compare one bit wider so a saturated count cannot wrap to zero
      if (adj_req_in.down_req && ({1'b0, elapsed_r} + 13'h1) >= {1'b0, dec_wait}) begin
        down_nxt = 1'b1;
        elapsed_nxt = '0;
      end else if (adj_req_in.up_req && ({1'b0, elapsed_r} + 13'h1) >= {1'b0, inc_wait}) begin
        up_nxt = 1'b1;
        elapsed_nxt = '0;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      elapsed_r <= '0;
      up_r <= 1'b0;
      down_r <= 1'b0;
    end else begin
      elapsed_r <= elapsed_nxt;
      up_r <= up_nxt;
      down_r <= down_nxt;
    end
  end

  assign adj_up_out = up_r;
  assign adj_down_out = down_r;
endmodule // peci_fan_start_temperature_cycle_timing

/* tb/peci_fan_start_temperature_assertions.sv */
`timescale 1ns/10ps
module fan_start_temperature_chk import peci_fan_start_temperature_pkg::*; (
  // watched ports
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire reg_req_t reg_req_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic lock_in,
  input wire logic adj_up_out,
  input wire logic adj_down_out,
  input wire logic [2:0] peci_cycle_select_out,
  input wire logic dyn_enable_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  wire ad = reg_req_in.addr == CTRL_OFFSET;
  wire acc = reg_req_in.write && ad && !lock_in;
  wire [3:0] wv = {reg_req_in.wdata[7], reg_req_in.wdata[5:3]};
  wire [3:0] cv = {dyn_enable_out, peci_cycle_select_out};
  wire [1:0] pl = {adj_up_out, adj_down_out};
  a_rsv_zero: assert property (reg_rdata_out[2:0] == 3'h0) else $error("rsv");
  a_ctrl_wr: assert property (acc |=> cv == $past(wv)) else $error("wr");
  a_lock_hold: assert property (lock_in |=> $stable(cv)) else $error("lock");
  a_rd_other: assert property (!ad |=> reg_rdata_out == 8'h00) else $error("rd");
  a_off_quiet: assert property (!dyn_enable_out [*2] |-> pl == 2'h0) else $error("o");
  a_one_dir: assert property (pl != 2'h3) else $error("both");
  a_down_gap: assert property (pl[0] |=> (!pl[0]) [*8]) else $error("dn");
  a_up_gap: assert property (pl[1] |=> (!pl[1]) [*8]) else $error("up");
  c_down: cover property (pl[0]);
  c_up: cover property (pl[1]);
  c_lock: cover property (lock_in && reg_req_in.write);
endmodule // fan_start_temperature_chk
bind peci_fan_start_temperature_cycle_timing fan_start_temperature_chk fan_start_temperature_chk_i (.*);

/* tb/testbench.sv */
`timescale 1ns/10ps
module testbench import peci_fan_start_temperature_pkg::*;;
  logic core_clk_in = 1'b0, rstn_in = 1'b0, lock_in = 1'b0;
  logic adj_up_out, adj_down_out, dyn_enable_out;
  logic [7:0] reg_rdata_out;
  logic [2:0] peci_cycle_select_out;
  reg_req_t reg_req_in = '{1'b0, CTRL_OFFSET, 8'h00};
  adj_req_t adj_req_in = '0;
  int failures = 0, total_checks = 0;
  peci_fan_start_temperature_cycle_timing #(.MON_PERIOD(4)) peci_fan_start_temperature_cycle_timing_i (.*);
  initial forever #50 core_clk_in = ~core_clk_in;
  task automatic report_and_stop();
    $display("%0d checks %0d bad", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(logic [31:0] g, e);
    total_checks++;
    if (g !== e) failures++;
    if (g !== e) $display("BAD %0t %h %h", $time, g, e);
  endtask
  task automatic wr(logic [7:0] a, d, logic k, logic [7:0] e);
    @(negedge core_clk_in) reg_req_in = '{1'b1, a, d};
    lock_in = k;
    @(negedge core_clk_in) reg_req_in.write = 1'b0;
    @(negedge core_clk_in) chk(reg_rdata_out, e);
  endtask
  task automatic gap(bit u, int e);
    int n;
    adj_req_in = '{u, ~u};
    repeat (2) for (n = 1; n < 20000; n++) // first pulse only aligns the count
      @(negedge core_clk_in) if ((u ? adj_up_out : adj_down_out) === 1'b1) break;
    chk(n, e);
    if (n >= 20000) report_and_stop();
  endtask
  task automatic t_reg();
    adj_req_in = '1;
    chk(reg_rdata_out, CTRL_RESET);
    repeat (64) @(negedge core_clk_in) chk({adj_up_out, adj_down_out}, 0);
    wr(CTRL_OFFSET, 8'hFF, 1'b0, 8'hF8);
    wr(CTRL_OFFSET, 8'h00, 1'b1, 8'hF8);
    wr(8'h94, 8'hFF, 1'b0, 8'h00);
    $display("reg done");
  endtask
  task automatic t_gap(logic [2:0] c);
    wr(CTRL_OFFSET, {2'b10, c, 3'h0}, 1'b0, {2'b10, c, 3'h0});
    chk({dyn_enable_out, peci_cycle_select_out}, {1'b1, c});
    gap(1'b0, (DEC_BASE_CYCLES << c) * 4);
    gap(1'b1, (INC_BASE_CYCLES << c) * 4);
    $display("code %0d done", c);
  endtask
  task automatic t_idle();
    int n;
    adj_req_in = '0;
    wr(CTRL_OFFSET, 8'h80, 1'b0, 8'h80);
    repeat (16400) @(negedge core_clk_in);
    adj_req_in = '{1'b0, 1'b1};
    for (n = 1; n < 20; n++) @(negedge core_clk_in) if (adj_down_out === 1'b1) break;
    chk(n < 10, 1);
    $display("idle done");
  endtask
  initial begin
    repeat (20) @(negedge core_clk_in);
    rstn_in = 1'b1;
    t_reg();
    for (int c = 0; c < 8; c++) t_gap(c[2:0]);
    t_idle();
    report_and_stop();
  end
endmodule // testbench
